// ---- inc/pmmp_regs.vh ----
// constants for the mii phy port and its management responder
`ifndef PMMP_REGS_VH
`define PMMP_REGS_VH
// apb register byte offsets
`define PMMP_CTRL_OFS 8'h00
`define PMMP_STAT_OFS 8'h04
// control register fields
`define PMMP_CTRL_SPEED 0
`define PMMP_CTRL_FDX 1
`define PMMP_CTRL_LINK 2
`define PMMP_CTRL_RESET 3'h0
// interface mode strap codes
`define PMMP_MODE_MII 3'h0
`define PMMP_MODE_B2B 3'h6
// line symbol kinds
`define PMMP_K_IDLE 3'h0
`define PMMP_K_DATA 3'h1
`define PMMP_K_PRE 3'h2
`define PMMP_K_SFD 3'h3
`define PMMP_K_EOF 3'h4
`define PMMP_K_JK 3'h5
`define PMMP_K_TR 3'h6
`define PMMP_K_ERR 3'h7
// management frame
`define PMMP_PRE_ONES 6'h20
`define PMMP_HDR_BITS 5'h0e
`define PMMP_DATA_BITS 5'h10
`define PMMP_OP_READ 2'h2
`define PMMP_OP_WRITE 2'h1
`define PMMP_START 2'h1
`define PMMP_REG_VENDOR 5'h16
`define PMMP_BCAST_BIT 9
`define PMMP_REG_STATUS 5'h01
`define PMMP_LINK_BIT 2
// first nibble of preamble in 100Mbps mode
`define PMMP_PRE_NIB 4'h5
`endif

// ---- rtl/pmmp_top.v ----
// mii phy nibble paths, clocks, carrier and collision, and management responder
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "pmmp_regs.vh"
module pmmp_top #(
  parameter HALF_10 = 4,
  parameter HALF_100 = 1
) (
  // system
  input wire CLK_SYS,
  input wire RESETN,
  // straps
  input wire [2:0] CONFIG_STRAP,
  input wire [2:0] NODE_ADDRESS_STRAP,
  input wire BROADCAST_DISABLE_STRAP,
  // mii toward mac
  output reg TXC,
  input wire TXEN,
  input wire [3:0] TXD,
  output reg RXC,
  output reg RXDV,
  output reg [3:0] RXD,
  output reg RXER,
  output reg CRS,
  output reg COL,
  // line side (decoded symbols in, nibbles out)
  input wire [2:0] LINE_KIND,
  input wire [3:0] LINE_DATA,
  output reg LINE_TX_EN,
  output reg [3:0] LINE_TX_DATA,
  output reg RXC_FROM_LINE,
  // management
  input wire MDC,
  input wire MDIO_IN,
  output reg MDIO_OUT,
  output reg MDIO_OEN,
  // apb
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR
);

  localparam R_IDLE = 2'h0;
  localparam R_PRE = 2'h1;
  localparam R_FRM = 2'h2;
  localparam M_PRE = 2'h0;
  localparam M_HDR = 2'h1;
  localparam M_RD = 2'h2;
  localparam M_WR = 2'h3;

  // pin filter: a bit moves once stages two and three agree
  function [6:0] agree;
    input [6:0] s2;
    input [6:0] s3;
    input [6:0] held;
    begin
      agree = (~(s2 ^ s3) & s2) | ((s2 ^ s3) & held);
    end
  endfunction

  reg [6:0] sy1;
  reg [6:0] sy2;
  reg [6:0] sy3;
  reg [6:0] pin;
  reg [2:0] mode;
  reg [2:0] own_addr;
  reg bcast_strap;
  reg [2:0] ctrl;
  reg [7:0] div_cnt;
  reg [1:0] rx_st;
  reg mdc_d;
  reg [1:0] md_st;
  reg [5:0] pre_cnt;
  reg [4:0] bit_cnt;
  reg [13:0] hdr;
  reg [15:0] shreg;
  reg [15:0] mregs [0:31];
  integer i;

  wire b2b = (mode == `PMMP_MODE_B2B);
  wire speed100 = ctrl[`PMMP_CTRL_SPEED] | b2b;
  wire fdx = ctrl[`PMMP_CTRL_FDX];
  wire link = ctrl[`PMMP_CTRL_LINK];
  wire [7:0] half = speed100 ? HALF_100[7:0] : HALF_10[7:0];
  wire tick = (div_cnt >= half - 8'h01);
  wire t_rise = tick & ~TXC;
  wire t_fall = tick & TXC;
  wire p_txen = pin[6];
  wire [3:0] p_txd = pin[5:2];
  wire p_mdc = pin[1];
  wire p_mdio = pin[0];
  wire md_rise = p_mdc & ~mdc_d;
  wire bcast_on = ~bcast_strap & ~mregs[`PMMP_REG_VENDOR][`PMMP_BCAST_BIT];
  wire [13:0] hdr_n = {hdr[12:0], p_mdio};
  wire [4:0] phy_f = hdr_n[9:5];
  wire [4:0] reg_f = hdr_n[4:0];
  wire hit = (phy_f == {2'h0, own_addr}) | (phy_f == 5'h00 & bcast_on);
  wire [15:0] rd_word = (reg_f == `PMMP_REG_STATUS) ?
    (mregs[reg_f] | ({15'h0000, link} << `PMMP_LINK_BIT)) : mregs[reg_f];
  wire apb_acc = PSEL & PENABLE & PREADY;
  wire ofs_ok = (PADDR == `PMMP_CTRL_OFS) | (PADDR == `PMMP_STAT_OFS);

  // three-stage pin synchronisers; only stage two reads stage one
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      sy1 <= 7'h00;
      sy2 <= 7'h00;
      sy3 <= 7'h00;
      pin <= 7'h00;
      mdc_d <= 1'b0;
    end else begin
      sy1 <= {TXEN, TXD, MDC, MDIO_IN};
      sy2 <= sy1;
      sy3 <= sy2;
      pin <= agree(sy2, sy3, pin);
      mdc_d <= p_mdc;
    end
  end

  // straps are caught every clock while reset is held, so the released value stays
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      mode <= CONFIG_STRAP;
      own_addr <= NODE_ADDRESS_STRAP;
      bcast_strap <= BROADCAST_DISABLE_STRAP;
    end
  end

  // one divider makes both mii clocks; receive clock runs even when idle
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      div_cnt <= 8'h00;
      TXC <= 1'b0;
      RXC <= 1'b0;
    end else if (tick) begin
      div_cnt <= 8'h00;
      TXC <= ~TXC;
      RXC <= ~RXC;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // receive clock source: line in 100M whenever linked, in 10M only with carrier
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      RXC_FROM_LINE <= 1'b0;
    end else begin
      RXC_FROM_LINE <= link & (speed100 | CRS);
    end
  end

  // transmit nibbles taken at the transmit clock rising edge; data ignored while idle
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      LINE_TX_EN <= 1'b0;
      LINE_TX_DATA <= 4'h0;
    end else if (t_rise) begin
      LINE_TX_EN <= p_txen;
      LINE_TX_DATA <= p_txen ? p_txd : 4'h0;
    end
  end

  // collision is re-evaluated every system clock, not on either mii clock
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      COL <= 1'b0;
    end else begin
      COL <= ~fdx & LINE_TX_EN & CRS;
    end
  end

  // receive framing; outputs move on the falling receive edge so they are stable at rise
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      rx_st <= R_IDLE;
      CRS <= 1'b0;
      RXDV <= 1'b0;
      RXD <= 4'h0;
      RXER <= 1'b0;
    end else if (t_fall) begin
      RXER <= 1'b0;
      if (!link) begin
        rx_st <= R_IDLE;
        CRS <= 1'b0;
        RXDV <= 1'b0;
        RXD <= 4'h0;
      end else begin
        case (rx_st)
          R_IDLE: begin
            if (speed100 && LINE_KIND == `PMMP_K_JK) begin
              rx_st <= R_FRM;
              CRS <= 1'b1;
              RXDV <= 1'b1;
              RXD <= `PMMP_PRE_NIB;
            end else if (!speed100 && LINE_KIND == `PMMP_K_PRE) begin
              rx_st <= R_PRE;
              CRS <= 1'b1;
            end
          end
          R_PRE: begin
            if (LINE_KIND == `PMMP_K_SFD) begin
              rx_st <= R_FRM;
              RXDV <= 1'b1;
              RXD <= LINE_DATA;
            end else if (LINE_KIND == `PMMP_K_EOF || LINE_KIND == `PMMP_K_IDLE) begin
              rx_st <= R_IDLE;
              CRS <= 1'b0;
            end
          end
          R_FRM: begin
            if ((!speed100 && LINE_KIND == `PMMP_K_EOF) ||
                (speed100 && (LINE_KIND == `PMMP_K_TR || LINE_KIND == `PMMP_K_IDLE))) begin
              rx_st <= R_IDLE;
              CRS <= 1'b0;
              RXDV <= 1'b0;
              RXD <= 4'h0;
            end else begin
              RXD <= LINE_DATA;
              RXER <= (LINE_KIND == `PMMP_K_ERR);
            end
          end
          default: begin
            rx_st <= R_IDLE;
          end
        endcase
      end
    end
  end

  // management responder, every step on a filtered rising management clock
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      md_st <= M_PRE;
      pre_cnt <= 6'h00;
      bit_cnt <= 5'h00;
      hdr <= 14'h0000;
      shreg <= 16'h0000;
      MDIO_OUT <= 1'b0;
      MDIO_OEN <= 1'b1;
      for (i = 0; i < 32; i = i + 1) begin
        mregs[i] <= 16'h0000;
      end
    end else if (md_rise) begin
      case (md_st)
        M_PRE: begin
          if (p_mdio) begin
            if (pre_cnt != `PMMP_PRE_ONES) begin
              pre_cnt <= pre_cnt + 6'h01;
            end
          end else if (pre_cnt == `PMMP_PRE_ONES) begin
            md_st <= M_HDR;
            hdr <= 14'h0000;
            bit_cnt <= 5'h01;
          end else begin
            pre_cnt <= 6'h00;
          end
        end
        M_HDR: begin
          hdr <= hdr_n; // msb first
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `PMMP_HDR_BITS - 5'h01) begin
            bit_cnt <= 5'h00;
            pre_cnt <= 6'h00;
            md_st <= M_PRE;
            if (hdr_n[13:12] == `PMMP_START && hit) begin
              if (hdr_n[11:10] == `PMMP_OP_READ) begin
                // line stays released through the first turnaround bit
                md_st <= M_RD;
                shreg <= rd_word;
              end else if (hdr_n[11:10] == `PMMP_OP_WRITE) begin
                md_st <= M_WR;
              end
            end
          end
        end
        M_RD: begin
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == 5'h00) begin
            // the controller lets go in the first turnaround bit, so take the line only now
            MDIO_OUT <= 1'b0;
            MDIO_OEN <= 1'b0;
          end else if (bit_cnt == `PMMP_DATA_BITS + 5'h01) begin
            MDIO_OUT <= 1'b0;
            MDIO_OEN <= 1'b1;
            md_st <= M_PRE;
            bit_cnt <= 5'h00;
          end else begin
            MDIO_OUT <= shreg[15];
            shreg <= {shreg[14:0], 1'b0};
          end
        end
        M_WR: begin
          // the two turnaround bits are counted but their value is not checked
          bit_cnt <= bit_cnt + 5'h01;
          shreg <= {shreg[14:0], p_mdio};
          if (bit_cnt == `PMMP_DATA_BITS + 5'h01) begin
            mregs[hdr[4:0]] <= {shreg[14:0], p_mdio};
            md_st <= M_PRE;
            bit_cnt <= 5'h00;
          end
        end
        default: begin
          md_st <= M_PRE;
        end
      endcase
    end
  end

  // apb slave: one wait state, write lands at the edge that sees pready high
  always @(posedge CLK_SYS) begin
    if (!RESETN) begin
      ctrl <= `PMMP_CTRL_RESET;
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      if (PSEL && PENABLE && !PREADY) begin
        PSLVERR <= ~ofs_ok;
        if (!PWRITE && PADDR == `PMMP_CTRL_OFS) begin
          PRDATA <= {29'h00000000, ctrl};
        end else if (!PWRITE && PADDR == `PMMP_STAT_OFS) begin
          PRDATA <= {20'h00000, RXC_FROM_LINE, COL, RXDV, CRS, b2b, bcast_strap, own_addr, mode};
        end else begin
          PRDATA <= 32'h00000000;
        end
      end else begin
        PSLVERR <= 1'b0;
      end
      if (apb_acc && PWRITE && PADDR == `PMMP_CTRL_OFS) begin
        ctrl <= PWDATA[2:0];
      end
    end
  end

endmodule // pmmp_top

// ---- bench/pmmp_asserts.sv ----
// assertion checker for the mii phy port and management responder
`timescale 1ns/1ns
module pmmp_chk (
  // system
  input logic CLK_SYS,
  input logic RESETN,
  // mii
  input logic TXC,
  input logic RXC,
  input logic RXDV,
  input logic [3:0] RXD,
  input logic RXER,
  input logic CRS,
  input logic COL,
  input logic LINE_TX_EN,
  input logic [3:0] LINE_TX_DATA,
  // management and apb
  input logic MDIO_OUT,
  input logic MDIO_OEN,
  input logic PSEL,
  input logic PENABLE,
  input logic [7:0] PADDR,
  input logic PREADY,
  input logic PSLVERR
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  // a read drive opens with a turnaround zero and then holds the line
  sequence s_drive;
    !MDIO_OUT ##0 !MDIO_OEN [*8];
  endsequence
  property p_txc; $rose(TXC) |-> ##[1:8] $fell(TXC); endproperty
  a_txc: assert property (p_txc) else $error("transmit clock stalled");
  property p_txidle; !LINE_TX_EN |-> LINE_TX_DATA == 4'h0; endproperty
  a_txidle: assert property (p_txidle) else $error("idle nibble not zero");
  // receive outputs may move only where the receive clock falls
  property p_rxsync; !$stable({RXDV, RXD, RXER, CRS}) |-> $fell(RXC); endproperty
  a_rxsync: assert property (p_rxsync) else $error("receive output off clock");
  property p_dv; RXDV |-> CRS; endproperty
  a_dv: assert property (p_dv) else $error("valid without carrier");
  property p_er; RXER |-> CRS; endproperty
  a_er: assert property (p_er) else $error("error outside frame");
  property p_col; $rose(COL) |-> $past(LINE_TX_EN && CRS); endproperty
  a_col: assert property (p_col) else $error("collision without traffic");
  property p_rd; $fell(MDIO_OEN) |-> s_drive; endproperty
  a_rd: assert property (p_rd) else $error("bad read drive");
  // one wait state, then a single-cycle ready
  property p_rdy; PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("apb ready timing");
  property p_slverr; PREADY && PADDR > 8'h04 |-> PSLVERR; endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped offset accepted");
endmodule // pmmp_chk
bind pmmp_top pmmp_chk pmmp_chk_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .TXC(TXC), .RXC(RXC), .RXDV(RXDV),
  .RXD(RXD), .RXER(RXER), .CRS(CRS), .COL(COL), .LINE_TX_EN(LINE_TX_EN), .LINE_TX_DATA(LINE_TX_DATA),
  .MDIO_OUT(MDIO_OUT), .MDIO_OEN(MDIO_OEN), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY),
  .PSLVERR(PSLVERR));

// ---- bench/pmmp_mac.sv ----
// mac and management controller model facing the phy
`timescale 1ns/1ns
module pmmp_mac (
  // clocks
  input wire logic clk,
  input wire logic txc,
  // mii transmit
  output logic txen,
  output logic [3:0] txd,
  // management
  output logic mdc,
  output wire logic mdio,
  input wire logic mdio_out,
  input wire logic mdio_oen
);
  logic ctl_en;
  logic ctl_bit;
  logic [3:0] sent[$];
  // pulled-up line, so a released line never shows a stale bit
  assign mdio = !mdio_oen ? mdio_out : (ctl_en ? ctl_bit : 1'b1);
  initial begin
    txen = 1'b0;
    txd = 4'h0;
    mdc = 1'b0;
    ctl_en = 1'b0;
    ctl_bit = 1'b1;
  end
  // random nibbles, changed just after the transmit clock rises
  task automatic tx_frame(input int n);
    logic [3:0] v;
    for (int i = 0; i < n; i++) begin
      @(posedge txc);
      v = 4'($urandom);
      txen <= 1'b1;
      txd <= v;
      sent.push_back(v);
    end
    @(posedge txc);
    txen <= 1'b0;
    txd <= 4'h0;
  endtask
  // mdc held 6 clocks a phase: slow but well under the 10MHz ceiling
  task automatic mgmt(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [16:0] rd);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    rd = '0;
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk);
      mdc <= 1'b0;
      ctl_en <= !(op == 2'h2 && i < 18);
      ctl_bit <= f[i];
      repeat (6) @(posedge clk);
      rd = {rd[15:0], mdio};
      mdc <= 1'b1;
      repeat (5) @(posedge clk);
    end
    @(posedge clk);
    mdc <= 1'b0;
    ctl_en <= 1'b0;
  endtask
endmodule // pmmp_mac

// ---- bench/tb.sv ----
// self-checking bench for the mii phy port and management responder
`timescale 1ns/1ns
module tb;
  logic CLK_SYS, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, BROADCAST_DISABLE_STRAP;
  logic TXC, TXEN, RXC, RXDV, RXER, CRS, COL, LINE_TX_EN, RXC_FROM_LINE, MDC, MDIO_OUT, MDIO_OEN;
  logic [2:0] CONFIG_STRAP, NODE_ADDRESS_STRAP, LINE_KIND, node;
  logic [3:0] TXD, RXD, LINE_DATA, LINE_TX_DATA;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic [15:0] mr[32];
  logic [15:0] wd;
  logic [4:0] own;
  logic e;
  wire MDIO_IN;
  int n_fail, comparisons, cyc, crs, dv, er, rd;
  pmmp_top #(.HALF_10(4), .HALF_100(1)) pmmp_top_inst (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
    .CONFIG_STRAP(CONFIG_STRAP), .NODE_ADDRESS_STRAP(NODE_ADDRESS_STRAP),
    .BROADCAST_DISABLE_STRAP(BROADCAST_DISABLE_STRAP), .TXC(TXC), .TXEN(TXEN), .TXD(TXD), .RXC(RXC),
    .RXDV(RXDV), .RXD(RXD), .RXER(RXER), .CRS(CRS), .COL(COL), .LINE_KIND(LINE_KIND), .LINE_DATA(LINE_DATA),
    .LINE_TX_EN(LINE_TX_EN), .LINE_TX_DATA(LINE_TX_DATA), .RXC_FROM_LINE(RXC_FROM_LINE), .MDC(MDC),
    .MDIO_IN(MDIO_IN), .MDIO_OUT(MDIO_OUT), .MDIO_OEN(MDIO_OEN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
  pmmp_mac pmmp_mac_inst (.clk(CLK_SYS), .txc(TXC), .txen(TXEN), .txd(TXD), .mdc(MDC),
    .mdio(MDIO_IN), .mdio_out(MDIO_OUT), .mdio_oen(MDIO_OEN));
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic rst(input logic [2:0] cfg, input logic bc);
    @(posedge CLK_SYS);
    CONFIG_STRAP <= cfg;
    BROADCAST_DISABLE_STRAP <= bc;
    RESETN <= 1'b0;
    repeat (8) @(posedge CLK_SYS);
    RESETN <= 1'b1;
  endtask
  // no fixed latency assumed: wait for ready under the global timeout
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // one line symbol per receive period, kinds one hex digit each
  task automatic rx_run(input logic [63:0] ks, input int fast);
    logic [3:0] d;
    @(negedge RXC);
    @(posedge CLK_SYS);
    for (int i = 60; i >= 0; i -= 4) begin
      d = 4'($urandom);
      LINE_KIND <= ks[i+:3];
      LINE_DATA <= d;
      @(negedge RXC);
      @(posedge CLK_SYS);
      er = 0;
      case (ks[i+:3])
        3'h1: rd = d;
        3'h2: crs = crs | !fast;
        3'h3: if (!fast && crs) begin
          dv = 1;
          rd = d;
        end
        3'h5: if (fast) begin
          crs = 1;
          dv = 1;
          rd = 5;
        end
        3'h7: begin
          er = dv;
          rd = d;
        end
        default: begin
          crs = 0;
          dv = 0;
        end
      endcase
      chk("carrier valid error", {crs[0], dv[0], er[0]}, {CRS, RXDV, RXER});
      if (dv) chk("rxd", rd, RXD);
    end
  endtask
  // management frame against a register model
  task automatic mx(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] w);
    logic [16:0] got;
    logic acc;
    acc = pa == own || (pa == 5'h0 && !mr[22][9]);
    pmmp_mac_inst.mgmt(op, pa, ra, w, got);
    if (op == 2'h1 && acc) mr[ra] = w;
    if (op == 2'h2)
      chk("mdio read", acc ? {1'b0, mr[ra] | (ra == 5'h1 ? 16'h4 : 16'h0)} : 17'h1ffff, got);
  endtask
  // nibbles leaving on the line side must be those the mac sent
  always @(posedge TXC) begin
    #1;
    if (LINE_TX_EN === 1'b1) chk("line nibble", pmmp_mac_inst.sent.pop_front(), LINE_TX_DATA);
  end
  initial begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end
  // the whole run needs about 7200 cycles
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    {RESETN, PSEL, PENABLE, PWRITE, BROADCAST_DISABLE_STRAP, PADDR, PWDATA} = '0;
    {CONFIG_STRAP, LINE_KIND, LINE_DATA} = '0;
    foreach (mr[i]) mr[i] = 16'h0;
    void'($urandom(63));
    node = 3'($urandom_range(7, 1));
    own = {2'h0, node};
    NODE_ADDRESS_STRAP = node;
    rst(3'h6, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", {2'b11, node, 3'h6}, r[7:0]);
    rst(3'h0, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk("status", {2'b00, node, 3'h0}, r[7:0]);
    apb(1'b0, 8'h08, 32'h0);
    chk("slverr", 1, e);
    chk("bad offset data", 0, r);
    $display("test straps done");
    apb(1'b1, 8'h00, 32'h4);
    // linked at 10M with no carrier: receive clock from the reference
    apb(1'b0, 8'h04, 32'h0);
    chk("clock source", 4'h0, r[11:8]);
    fork
      pmmp_mac_inst.tx_frame(12);
      rx_run(64'h5223_1117_1402_4000, 0);
    join
    chk("nibbles left", 0, pmmp_mac_inst.sent.size());
    $display("test 10M done");
    apb(1'b1, 8'h00, 32'h5);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h5, r);
    rx_run(64'h2511_7116_0511_0000, 1);
    // linked at 100M: receive clock recovered from the line even when idle
    apb(1'b0, 8'h04, 32'h0);
    chk("clock source", 4'h8, r[11:8]);
    $display("test 100M done");
    wd = 16'($urandom);
    mx(2'h1, own, 5'h03, wd);
    mx(2'h2, own, 5'h03, 16'h0);
    mx(2'h2, own, 5'h01, 16'h0);
    mx(2'h1, 5'h00, 5'h04, ~wd);
    mx(2'h2, own, 5'h04, 16'h0);
    mx(2'h2, {2'h0, 3'(node % 7 + 1)}, 5'h03, 16'h0);
    mx(2'h1, own, 5'h16, 16'h0200);
    mx(2'h1, 5'h00, 5'h04, wd);
    mx(2'h2, own, 5'h04, 16'h0);
    $display("test management done");
    close_out();
  end
endmodule // tb
